// File: dv/pmbus_mfr_command_set_bench.sv
// Bench: AXI4-Lite host driving the command set over the link
`default_nettype none
module pmbus_mfr_command_set_bench
	import pmc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] IDS [4] = '{CMD_MAKER_ID, CMD_MODEL_ID, CMD_PRODUCT_REV, CMD_UNIT_SERIAL};
	logic clock = 0, sys_rst = 1, clk_en = 1, lim = 0, uv = 0, on_req = 1;
	logic [10:0] iout = 0;
	logic [3:0] awa = 0, ara = 0, wst = 0;
	logic [31:0] wd = 0;
	logic awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
	wire logic awr, wrr, bv, arr, rv, al_n, en, nv, hold;
	wire logic [1:0] br, rr;
	wire logic [31:0] rd;
	wire logic [71:0] img;
	wire logic [2:0] ovf, ovw, uvl;
	int bad_count = 0, checked = 0, stores = 0;
	pmc_link_if link ();
	// Short delay and hiccup counts keep the run brief; chip codes are arbitrary
	pmc_device #(.chip_type_value(8'h3c), .chip_revision_value(8'h07), .delay_cycles_per_us(1), .hiccup_cycles(50))
		pmc_device_inst (.clock, .sys_rst, .clk_en, .link(link.device), .avg_iout_mantissa(iout),
		.current_limiting(lim), .output_undervoltage_event(uv), .output_on_request(on_req), .alert_out_n(al_n),
		.regulator_enable(en), .current_limit_hold(hold), .nvm_store_valid(nv), .nvm_image(img),
		.overvoltage_fault_level(ovf), .overvoltage_warning_level(ovw), .undervoltage_level(uvl));
	pmc_host pmc_host_inst (.clock, .sys_rst, .clk_en, .link(link.host), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(wst), .s_axi_wvalid(wv), .s_axi_wready(wrr),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy));
	pmc_assertions pmc_assertions_inst (.clock, .sys_rst, .req_valid(link.req_valid), .req_ready(link.req_ready),
		.req_write(link.req_write), .req_cmd(link.req_cmd), .req_data(link.req_data), .rsp_valid(link.rsp_valid),
		.rsp_nack(link.rsp_nack), .rsp_data(link.rsp_data), .alert_out_n(al_n), .output_on_request(on_req));
	initial forever #4 clock = ~clock;
	always @(posedge clock) if (nv) stores++;
	task automatic report_and_stop();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic axw(input logic [3:0] a, input logic [31:0] d);
		awa <= a;
		wd <= d;
		wst <= 4'hf;
		awv <= 1;
		wv <= 1;
		brdy <= 1;
		do begin
			@(posedge clock);
			if (awr) awv <= 0;
			if (wrr) wv <= 0;
		end while (!bv);
		brdy <= 0;
		@(posedge clock);
	endtask : axw
	task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		ara <= a;
		arv <= 1;
		rrdy <= 1;
		do begin
			@(posedge clock);
			if (arr) arv <= 0;
		end while (!rv);
		d = rd;
		r = rr;
		rrdy <= 0;
		@(posedge clock);
	endtask : axr
	// Launch one command and wait for the host to see its answer
	task automatic pm(input logic w, input logic [7:0] c, input logic [1:0] l, input logic [15:0] d,
		output logic [15:0] q, output logic nk);
		logic [31:0] s;
		logic [1:0] r;
		axw(4'h4, {16'h0, d});
		axw(4'h0, {15'h0, w, 6'h0, l, c});
		do axr(4'h8, s, r); while (s[0] !== 1'b0);
		nk = s[1];
		axr(4'hc, s, r);
		q = s[15:0];
	endtask : pm
	task automatic rdv(input logic [7:0] c, input logic [1:0] l, input logic [15:0] e);
		logic [15:0] q;
		logic nk;
		pm(0, c, l, 16'h0, q, nk);
		chk("read", {8'h0, c, e}, {7'h0, nk, c, q});
	endtask : rdv
	task automatic wrv(input logic [7:0] c, input logic [1:0] l, input logic [15:0] d, input logic e);
		logic [15:0] q;
		logic nk;
		pm(1, c, l, d, q, nk);
		chk("write nack", {23'h0, e, c}, {23'h0, nk, c});
	endtask : wrv
	task automatic refuse_chk(input logic [7:0] c, input logic [15:0] d);
		logic [31:0] s;
		logic [1:0] r;
		axw(4'h4, {16'h0, d});
		axw(4'h0, {15'h0, 1'b1, 6'h0, LEN_WORD, c});
		axr(4'h8, s, r);
		chk("refused", 32'h4, {29'h0, s[2:0]});
		axw(4'h8, 32'h4);
	endtask : refuse_chk
	// Raise the measured current, look at the output, then clear the fault
	task automatic trip(input logic [7:0] rsp, input int t1, input logic e1, input int t2, input logic e2, input logic u);
		wrv(CMD_OC_RESPONSE, LEN_BYTE, {8'h0, rsp}, 0);
		iout <= 11'd40;
		repeat (t1) @(posedge clock);
		chk("enable early", e1, en);
		chk("hold", {31'h0, ~rsp[6]}, hold);
		iout <= 0;
		uv <= u;
		repeat (t2) @(posedge clock);
		chk("enable late", e2, en);
		chk("alert", 0, al_n);
		uv <= 0;
		lim <= 0;
		wrv(CMD_CLEAR_FAULTS, LEN_NONE, 16'h0, 0);
		chk("enable cleared", 1, en);
	endtask : trip
	initial begin : watchdog
		#400000;
		bad_count++;
		report_and_stop();
	end
	initial begin : main
		logic [31:0] s;
		logic [1:0] r;
		logic [7:0] v [4];
		logic [2:0] f, w, u;
		void'($urandom(32'he838));
		repeat (5) @(posedge clock);
		sys_rst <= 0;
		@(posedge clock);
		rdv(CMD_OC_RESPONSE, LEN_BYTE, 16'h0080);
		rdv(CMD_OC_LIMIT, LEN_WORD, 16'he340);
		rdv(CMD_PCT_THRESH, LEN_WORD, 16'h06e0);
		rdv(CMD_VOUT_FLOOR, LEN_WORD, 16'h0100);
		rdv(CMD_VOUT_CEIL, LEN_WORD, 16'h0b01);
		rdv(CMD_CHIP_TYPE, LEN_WORD, 16'h3c01);
		rdv(CMD_CHIP_REV, LEN_WORD, 16'h0701);
		wrv(CMD_VOUT_FLOOR, LEN_WORD, 16'h0200, 1);
		wrv(CMD_CHIP_TYPE, LEN_WORD, 16'h0101, 1);
		axr(4'h6, s, r);
		chk("unmapped resp", AXI_SLVERR, r);
		foreach (v[i]) begin
			v[i] = 8'($urandom);
			wrv(IDS[i], LEN_WORD, {~v[i], 8'h02}, 0);
			wrv(IDS[i], LEN_WORD, {v[i], 8'h01}, 0);
			rdv(IDS[i], LEN_WORD, {v[i], 8'h01});
		end
		wrv(CMD_STORE_ALL, LEN_NONE, 16'h0, 0);
		chk("image", {v[0], v[1], v[2], v[3]}, img[71:40]);
		chk("stores", 1, stores);
		for (int k = 1; k < 7; k++) wrv(CMD_OC_RESPONSE, LEN_BYTE, {10'h0, 3'(k), 3'h0}, 1);
		rdv(CMD_OC_RESPONSE, LEN_BYTE, 16'h0080);
		wrv(CMD_OC_LIMIT, LEN_WORD, 16'hd8a0, 1);
		s = 32'($urandom_range(2047, 1));
		wrv(CMD_OC_LIMIT, LEN_WORD, {5'h1c, s[10:0]}, 0);
		rdv(CMD_OC_LIMIT, LEN_WORD, {5'h1c, s[10:0]});
		repeat (3) begin
			f = 3'($urandom_range(7, 4));
			w = 3'($urandom_range(3, 2));
			u = 3'($urandom_range(1, 0));
			wrv(CMD_PCT_THRESH, LEN_WORD, {4'hf, f, w, u, 3'h7}, 0);
			rdv(CMD_PCT_THRESH, LEN_WORD, {4'h0, f, w, u, 3'h0});
			chk("levels", {f, w, u}, {ovf, ovw, uvl});
		end
		refuse_chk(CMD_OC_LIMIT, 16'he000);
		rdv(CMD_OC_LIMIT, LEN_WORD, {5'h1c, s[10:0]});
		refuse_chk(CMD_PCT_THRESH, 16'h01c0);
		rdv(CMD_PCT_THRESH, LEN_WORD, {4'h0, f, w, u, 3'h0});
		wrv(CMD_OC_LIMIT, LEN_WORD, 16'he010, 0);
		wrv(CMD_CLEAR_FAULTS, LEN_NONE, 16'h0, 0);
		clk_en <= 0;
		iout <= 11'd40;
		repeat (4) @(posedge clock);
		clk_en <= 1;
		iout <= 0;
		@(posedge clock);
		chk("frozen alert", 1, al_n);
		trip(8'h00, 10, 1, 10, 1, 0);
		iout <= 11'd40;
		repeat (3) @(posedge clock);
		iout <= 0;
		rdv(CMD_STATUS_WORD, LEN_WORD, 16'h4001);
		rdv(CMD_STATUS_BYTE, LEN_BYTE, 16'h0001);
		wrv(CMD_STATUS_MFR, LEN_BYTE, 16'h007f, 0);
		rdv(CMD_STATUS_MFR, LEN_BYTE, 16'h0080);
		wrv(CMD_STATUS_MFR, LEN_BYTE, 16'h0080, 0);
		rdv(CMD_STATUS_MFR, LEN_BYTE, 16'h0000);
		chk("alert cleared", 1, al_n);
		trip(8'h40, 10, 1, 10, 0, 1);
		lim <= 1;
		trip(8'h80, 100, 1, 100, 0, 0);
		trip(8'hc0, 10, 0, 100, 0, 0);
		trip(8'hf8, 10, 0, 80, 1, 0);
		report_and_stop();
	end
endmodule : pmbus_mfr_command_set_bench
`default_nettype wire

// File: dv/pmc_assertions.sv
// Checker on the command link between host controller and command set
`default_nettype none
module pmc_assertions
	import pmc_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic req_write,
	input wire logic [7:0] req_cmd,
	input wire logic [15:0] req_data,
	input wire logic rsp_valid,
	input wire logic rsp_nack,
	input wire logic [15:0] rsp_data,
	input wire logic alert_out_n,
	input wire logic output_on_request
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	wire tk = req_valid && req_ready;
	wire rd = tk && !req_write;
	wire wr = tk && req_write;
	a_rsp_after_take: assert property (tk |=> rsp_valid) else $error("no response");
	a_rsp_one_cycle: assert property (rsp_valid |=> !rsp_valid) else $error("long response");
	a_rsp_has_cause: assert property (rsp_valid |-> $past(tk)) else $error("stray response");
	a_floor_fixed: assert property (rd && req_cmd == CMD_VOUT_FLOOR |=> rsp_data == 16'h0100) else $error("floor");
	a_ceiling_fixed: assert property (rd && req_cmd == CMD_VOUT_CEIL |=> rsp_data == 16'h0b01) else $error("ceil");
	a_ro_write_refused: assert property (wr && req_cmd inside {8'ha4, 8'ha5, 8'had, 8'hae} |=> rsp_nack)
		else $error("read-only write taken");
	a_block_count_one: assert property (rd && req_cmd inside {8'h99, 8'h9a, 8'h9b, 8'h9e, 8'had, 8'hae}
		|=> rsp_data[7:0] == 8'h01 && !rsp_nack) else $error("block count");
	a_retry_refused: assert property (wr && req_cmd == 8'hc4 && req_data[5:3] inside {[1:6]} |=> rsp_nack)
		else $error("retry code taken");
	a_exponent_refused: assert property (wr && req_cmd == 8'hc5 && req_data[15:11] != 5'h1c |=> rsp_nack)
		else $error("exponent taken");
	a_thresh_unused_zero: assert property (rd && req_cmd == 8'hc6 |=> (rsp_data & 16'hf007) == 16'h0)
		else $error("unused bits");
	a_alert_stays: assert property (!alert_out_n && !tk && output_on_request && $past(output_on_request)
		|=> !alert_out_n) else $error("alert dropped");
	c_resp_write: cover property (wr && req_cmd == 8'hc4);
	c_nack: cover property (rsp_valid && rsp_nack);
	c_alert: cover property ($fell(alert_out_n));
endmodule : pmc_assertions
`default_nettype wire

// File: shared/pmc_link_if.sv
// Command link between the host controller and the regulator command set
`default_nettype none
interface pmc_link_if;
	logic req_valid;
	logic req_ready;
	logic req_write;
	logic [7:0] req_cmd;
	logic [1:0] req_len;
	logic [15:0] req_data;
	logic rsp_valid;
	logic rsp_nack;
	logic [15:0] rsp_data;
	modport device(input req_valid, req_write, req_cmd, req_len, req_data,
		output req_ready, rsp_valid, rsp_nack, rsp_data);
	modport host(output req_valid, req_write, req_cmd, req_len, req_data,
		input req_ready, rsp_valid, rsp_nack, rsp_data);
endinterface : pmc_link_if
`default_nettype wire

// File: shared/pmc_pkg.sv
// Command codes, field layouts, reset values and timing for the regulator command set
`default_nettype none
package pmc_pkg;
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_STORE_ALL = 8'h15;
	localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
	localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
	localparam logic [7:0] CMD_STATUS_CML = 8'h7e;
	localparam logic [7:0] CMD_STATUS_MFR = 8'h80;
	localparam logic [7:0] CMD_MAKER_ID = 8'h99;
	localparam logic [7:0] CMD_MODEL_ID = 8'h9a;
	localparam logic [7:0] CMD_PRODUCT_REV = 8'h9b;
	localparam logic [7:0] CMD_UNIT_SERIAL = 8'h9e;
	localparam logic [7:0] CMD_VOUT_FLOOR = 8'ha4;
	localparam logic [7:0] CMD_VOUT_CEIL = 8'ha5;
	localparam logic [7:0] CMD_CHIP_TYPE = 8'had;
	localparam logic [7:0] CMD_CHIP_REV = 8'hae;
	localparam logic [7:0] CMD_OC_RESPONSE = 8'hc4;
	localparam logic [7:0] CMD_OC_LIMIT = 8'hc5;
	localparam logic [7:0] CMD_PCT_THRESH = 8'hc6;
	localparam logic [15:0] VOUT_FLOOR_VALUE = 16'h0100;
	localparam logic [15:0] VOUT_CEIL_VALUE = 16'h0b01;
	localparam logic [15:0] OC_LIMIT_RESET = 16'he340;
	localparam logic [15:0] PCT_THRESH_RESET = 16'h06e0;
	localparam logic [15:0] PCT_THRESH_MASK = 16'h0ff8;
	localparam logic [7:0] OC_RESPONSE_RESET = 8'h80;
	localparam logic [7:0] IDENTITY_RESET = 8'h00;
	localparam logic [7:0] BLOCK_COUNT = 8'h01;
	localparam logic [4:0] OC_LIMIT_EXP = 5'h1c;
	localparam logic [1:0] LEN_NONE = 2'h0;
	localparam logic [1:0] LEN_BYTE = 2'h1;
	localparam logic [1:0] LEN_WORD = 2'h2;
	localparam int ACT_LO = 6;
	localparam int RETRY_LO = 3;
	localparam int DELAY_LO = 0;
	localparam int LIMIT_EXP_LO = 11;
	localparam int PCT_FAULT_LO = 9;
	localparam int PCT_WARN_LO = 6;
	localparam int PCT_UV_LO = 3;
	localparam logic [1:0] ACT_HOLD = 2'h0;
	localparam logic [1:0] ACT_UV_STOP = 2'h1;
	localparam logic [1:0] ACT_DELAY = 2'h2;
	localparam logic [1:0] ACT_SHUTDOWN = 2'h3;
	localparam logic [2:0] RETRY_LATCH = 3'h0;
	localparam logic [2:0] RETRY_HICCUP = 3'h7;
	localparam int CML_BAD_CMD = 7;
	localparam int CML_BAD_DATA = 6;
	localparam int MFR_OCP_AVG = 7;
	localparam int WORD_IOUT = 14;
	localparam int BYTE_CML = 1;
	localparam int BYTE_NOTA = 0;
	localparam int CLOCK_MHZ = 125;
	localparam int CYCLES_PER_US = CLOCK_MHZ;
	localparam int HICCUP_MS = 1000;
	localparam int HICCUP_CYCLES = HICCUP_MS * 1000 * CYCLES_PER_US;
	localparam int DELAY_MIN_US [8] = '{160, 320, 640, 1280, 2560, 5120, 9600, 10080};
	localparam int PCT_FAULT_BASE = 110;
	localparam int PCT_FAULT_STEP = 2;
	localparam int PCT_WARN_BASE = 102;
	localparam int PCT_WARN_STEP = 2;
	localparam int PCT_UV_BASE = 55;
	localparam int PCT_UV_STEP = 5;
	localparam logic [3:0] HOST_CMD_OFS = 4'h0;
	localparam logic [3:0] HOST_WDATA_OFS = 4'h4;
	localparam logic [3:0] HOST_STATUS_OFS = 4'h8;
	localparam logic [3:0] HOST_RDATA_OFS = 4'hc;
	localparam int HOST_WRITE_BIT = 16;
	localparam int HOST_LEN_LO = 8;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : pmc_pkg
`default_nettype wire

// File: src/pmc_device.sv
// Regulator command set: identity, voltage range, average over-current fault handling
// Overview of operation
// - identity commands use block format, count one
// - store command copies identity bytes to memory
// - floor reads fixed 0100h, read only
// - ceiling reads fixed 0b01h, read only
// - chip type/revision read as one-byte blocks
// - fault sets word, byte, mfr bits, alert
// - fault flag sticky until cleared or output_on_request rises
// - response resets to 80h, storable
// - code 00: keep running, hold current
// - code 01: run unless undervoltage seen
// - code 10: limit for delay, then retry if still limiting
// - code 11: shut down, then retry
// - retry 000: stay off until cleared
// - retry 111: restart every second forever
// - delay code picks limit window length
// - unsupported retry code flags invalid data
// - limit is LINEAR11, resets to E340h
// - limit exponent other than -4 invalid
// - host avoids zero limit; no range check
// - threshold fields: fault, warning, undervoltage
// - thresholds reset to 06E0h
// - host keeps warning<fault, undervoltage lowest
// - status write clears bits set in byte
//
// Design decision made here: the AXI4-Lite interface to the registers.
`default_nettype none
module pmc_device
	import pmc_pkg::*;
#(
	parameter logic [7:0] chip_type_value = 8'h5a,
	parameter logic [7:0] chip_revision_value = 8'h01,
	parameter int unsigned delay_cycles_per_us = CYCLES_PER_US,
	parameter int unsigned hiccup_cycles = HICCUP_CYCLES
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_en,
	pmc_link_if.device link,
	input wire logic [10:0] avg_iout_mantissa,
	input wire logic current_limiting,
	input wire logic output_undervoltage_event,
	input wire logic output_on_request,
	output logic alert_out_n,
	output logic regulator_enable,
	output logic current_limit_hold,
	output logic nvm_store_valid,
	output logic [71:0] nvm_image,
	output logic [2:0] overvoltage_fault_level,
	output logic [2:0] overvoltage_warning_level,
	output logic [2:0] undervoltage_level
);
	typedef enum logic [1:0] {ST_RUN, ST_DELAY, ST_LATCHED, ST_HICCUP} pmc_state_t;

	logic [7:0] ident [4];
	logic [7:0] oc_response;
	logic [15:0] oc_limit;
	logic [15:0] pct_thresh;
	logic ocp_flag;
	logic bad_cmd_flag;
	logic bad_data_flag;
	logic on_prev;
	pmc_state_t state;
	pmc_state_t next_state;
	logic [31:0] count;
	logic [31:0] next_count;
	logic [15:0] rd_value;
	logic rd_known;

	// The link stalls only while clk_en is low; the response always follows one enabled cycle later
	assign link.req_ready = clk_en;
	wire take = link.req_valid && clk_en;
	wire wr = take && link.req_write;
	wire rd = take && !link.req_write;
	wire [7:0] cmd = link.req_cmd;
	wire [15:0] wdat = link.req_data;

	wire is_ident = cmd == CMD_MAKER_ID || cmd == CMD_MODEL_ID || cmd == CMD_PRODUCT_REV || cmd == CMD_UNIT_SERIAL;
	wire [1:0] ident_idx = cmd == CMD_MAKER_ID ? 2'h0 : cmd == CMD_MODEL_ID ? 2'h1 :
		cmd == CMD_PRODUCT_REV ? 2'h2 : 2'h3;
	wire block_ok = link.req_len == LEN_WORD && wdat[7:0] == BLOCK_COUNT;
	wire [2:0] wr_retry = wdat[RETRY_LO +: 3];
	wire retry_bad = wr_retry != RETRY_LATCH && wr_retry != RETRY_HICCUP;
	wire limit_bad = wdat[LIMIT_EXP_LO +: 5] != OC_LIMIT_EXP || link.req_len != LEN_WORD;
	wire ident_wr = wr && is_ident && block_ok;
	wire resp_wr = wr && cmd == CMD_OC_RESPONSE && link.req_len == LEN_BYTE && !retry_bad;
	wire limit_wr = wr && cmd == CMD_OC_LIMIT && !limit_bad;
	wire pct_wr = wr && cmd == CMD_PCT_THRESH && link.req_len == LEN_WORD;
	wire status_wr = link.req_len == LEN_BYTE;
	wire clr_mfr = wr && cmd == CMD_STATUS_MFR && status_wr;
	wire clr_cml = wr && cmd == CMD_STATUS_CML && status_wr;
	wire store_all = wr && cmd == CMD_STORE_ALL;
	wire wr_bad_data = wr && ((is_ident && !block_ok) || (cmd == CMD_OC_RESPONSE && (retry_bad
		|| link.req_len != LEN_BYTE)) || (cmd == CMD_OC_LIMIT && limit_bad)
		|| (cmd == CMD_PCT_THRESH && link.req_len != LEN_WORD)
		|| ((cmd == CMD_STATUS_MFR || cmd == CMD_STATUS_CML) && !status_wr));
	wire wr_known = is_ident || cmd == CMD_OC_RESPONSE || cmd == CMD_OC_LIMIT || cmd == CMD_PCT_THRESH
		|| cmd == CMD_STATUS_MFR || cmd == CMD_STATUS_CML || cmd == CMD_CLEAR_FAULTS || cmd == CMD_STORE_ALL;
	// Writes to the fixed range and chip identity commands land here too
	wire bad_cmd = (wr && !wr_known) || (rd && !rd_known);
	wire on_rise = output_on_request && !on_prev;
	wire clear_all = (wr && cmd == CMD_CLEAR_FAULTS) || on_rise;

	// Both currents carry exponent -4, so mantissas compare directly
	wire fault_now = avg_iout_mantissa >= oc_limit[10:0];
	wire [1:0] act = oc_response[ACT_LO +: 2];
	wire [2:0] retry = oc_response[RETRY_LO +: 3];
	wire [2:0] delay_code = oc_response[DELAY_LO +: 3];
	wire [31:0] delay_load = 32'(DELAY_MIN_US[delay_code]) * 32'(delay_cycles_per_us) - 32'h1;
	wire [31:0] hiccup_load = 32'(hiccup_cycles) - 32'h1;
	wire pmc_state_t retry_state = retry == RETRY_HICCUP ? ST_HICCUP : ST_LATCHED;
	wire [31:0] retry_count = retry == RETRY_HICCUP ? hiccup_load : 32'h0;

	wire [7:0] cml_byte = {bad_cmd_flag, bad_data_flag, 6'h0};
	wire [7:0] mfr_byte = {ocp_flag, 7'h0};
	wire [7:0] status_byte = {6'h0, bad_cmd_flag | bad_data_flag, ocp_flag};
	wire [15:0] status_word = {1'b0, ocp_flag, 6'h0, status_byte};

	always_comb begin
		rd_known = 1'b1;
		case (cmd)
			CMD_MAKER_ID, CMD_MODEL_ID, CMD_PRODUCT_REV, CMD_UNIT_SERIAL: rd_value = {ident[ident_idx], BLOCK_COUNT};
			CMD_VOUT_FLOOR: rd_value = VOUT_FLOOR_VALUE;
			CMD_VOUT_CEIL: rd_value = VOUT_CEIL_VALUE;
			CMD_CHIP_TYPE: rd_value = {chip_type_value, BLOCK_COUNT};
			CMD_CHIP_REV: rd_value = {chip_revision_value, BLOCK_COUNT};
			CMD_OC_RESPONSE: rd_value = {8'h0, oc_response};
			CMD_OC_LIMIT: rd_value = oc_limit;
			CMD_PCT_THRESH: rd_value = pct_thresh & PCT_THRESH_MASK;
			CMD_STATUS_BYTE: rd_value = {8'h0, status_byte};
			CMD_STATUS_WORD: rd_value = status_word;
			CMD_STATUS_CML: rd_value = {8'h0, cml_byte};
			CMD_STATUS_MFR: rd_value = {8'h0, mfr_byte};
			default: begin
				rd_value = 16'h0;
				rd_known = 1'b0;
			end
		endcase
	end

	always_comb begin
		next_state = state;
		next_count = count;
		case (state)
			ST_RUN: begin
				if (fault_now && act == ACT_DELAY) begin
					next_state = ST_DELAY;
					next_count = delay_load;
				end else if ((fault_now && act == ACT_SHUTDOWN)
						|| (act == ACT_UV_STOP && (fault_now || ocp_flag) && output_undervoltage_event)) begin
					next_state = retry_state;
					next_count = retry_count;
				end
			end
			ST_DELAY: begin
				if (count != 32'h0) begin
					next_count = count - 32'h1;
				end else if (current_limiting) begin
					next_state = retry_state;
					next_count = retry_count;
				end else begin
					next_state = ST_RUN;
				end
			end
			ST_LATCHED: begin
				if (!ocp_flag) begin
					next_state = ST_RUN;
				end
			end
			ST_HICCUP: begin
				if (!output_on_request || count == 32'h0) begin
					next_state = ST_RUN;
				end else begin
					next_count = count - 32'h1;
				end
			end
			default: next_state = ST_RUN;
		endcase
	end

	for (genvar i = 0; i < 4; i++) begin : g_ident
		always_ff @(posedge clock) begin
			if (sys_rst) begin
				ident[i] <= IDENTITY_RESET;
			end else if (clk_en && ident_wr && ident_idx == 2'(i)) begin
				ident[i] <= wdat[15:8];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			oc_response <= OC_RESPONSE_RESET;
			oc_limit <= OC_LIMIT_RESET;
			pct_thresh <= PCT_THRESH_RESET;
		end else begin
			if (resp_wr) begin
				oc_response <= wdat[7:0];
			end
			if (limit_wr) begin
				oc_limit <= wdat;
			end
			if (pct_wr) begin
				pct_thresh <= wdat & PCT_THRESH_MASK;
			end
		end
	end

	// Setting wins over a clear arriving in the same cycle
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ocp_flag <= 1'b0;
			bad_cmd_flag <= 1'b0;
			bad_data_flag <= 1'b0;
			on_prev <= 1'b0;
		end else if (clk_en) begin
			on_prev <= output_on_request;
			ocp_flag <= fault_now || (ocp_flag && !(clear_all || (clr_mfr && wdat[MFR_OCP_AVG])));
			bad_cmd_flag <= bad_cmd || (bad_cmd_flag && !(clear_all || (clr_cml && wdat[CML_BAD_CMD])));
			bad_data_flag <= wr_bad_data
				|| (bad_data_flag && !(clear_all || (clr_cml && wdat[CML_BAD_DATA])));
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state <= ST_RUN;
			count <= 32'h0;
			regulator_enable <= 1'b0;
			current_limit_hold <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
			count <= next_count;
			regulator_enable <= output_on_request && (next_state == ST_RUN || next_state == ST_DELAY);
			current_limit_hold <= fault_now && (act == ACT_HOLD || act == ACT_DELAY) && next_state != ST_LATCHED
				&& next_state != ST_HICCUP;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			nvm_store_valid <= 1'b0;
			nvm_image <= 72'h0;
			link.rsp_valid <= 1'b0;
			link.rsp_nack <= 1'b0;
			link.rsp_data <= 16'h0;
		end else if (clk_en) begin
			nvm_store_valid <= store_all;
			if (store_all) begin
				nvm_image <= {ident[0], ident[1], ident[2], ident[3], oc_response, oc_limit, pct_thresh};
			end
			link.rsp_valid <= take;
			link.rsp_nack <= bad_cmd || wr_bad_data;
			link.rsp_data <= rd ? rd_value : 16'h0;
		end
	end

	assign alert_out_n = !(ocp_flag || bad_cmd_flag || bad_data_flag);
	assign overvoltage_fault_level = pct_thresh[PCT_FAULT_LO +: 3];
	assign overvoltage_warning_level = pct_thresh[PCT_WARN_LO +: 3];
	assign undervoltage_level = pct_thresh[PCT_UV_LO +: 3];
endmodule : pmc_device
`default_nettype wire

// File: src/pmc_host.sv
// Host controller: AXI4-Lite registers that launch commands over the link
`default_nettype none
module pmc_host
	import pmc_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_en,
	pmc_link_if.host link,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic aw_got;
	logic w_got;
	logic [3:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [15:0] wdata_reg;
	logic [15:0] rdata_reg;
	logic busy;
	logic nack;
	logic refused;

	assign s_axi_awready = clk_en && !aw_got && !s_axi_bvalid;
	assign s_axi_wready = clk_en && !w_got && !s_axi_bvalid;
	assign s_axi_arready = clk_en && !s_axi_rvalid;
	wire aw_now = aw_got || (s_axi_awvalid && s_axi_awready);
	wire w_now = w_got || (s_axi_wvalid && s_axi_wready);
	wire [3:0] wa = aw_got ? aw_addr : s_axi_awaddr;
	wire [31:0] wd = w_got ? w_data : s_axi_wdata;
	wire [3:0] ws = w_got ? w_strb : s_axi_wstrb;
	wire do_write = clk_en && aw_now && w_now && !s_axi_bvalid;
	wire wa_ok = wa == HOST_CMD_OFS || wa == HOST_WDATA_OFS || wa == HOST_STATUS_OFS;
	wire ar_ok = s_axi_araddr == HOST_CMD_OFS || s_axi_araddr == HOST_WDATA_OFS
		|| s_axi_araddr == HOST_STATUS_OFS || s_axi_araddr == HOST_RDATA_OFS;

	wire [7:0] new_cmd = wd[7:0];
	wire new_write = wd[HOST_WRITE_BIT];
	wire is_block = new_cmd == CMD_MAKER_ID || new_cmd == CMD_MODEL_ID || new_cmd == CMD_PRODUCT_REV
		|| new_cmd == CMD_UNIT_SERIAL;
	wire is_rd_block = is_block || new_cmd == CMD_CHIP_TYPE || new_cmd == CMD_CHIP_REV;
	wire [15:0] fwd = wdata_reg;
	wire [7:0] pct_fault = 8'(PCT_FAULT_BASE + PCT_FAULT_STEP * int'(fwd[PCT_FAULT_LO +: 3]));
	wire [7:0] pct_warn = 8'(PCT_WARN_BASE + PCT_WARN_STEP * int'(fwd[PCT_WARN_LO +: 3]));
	wire [7:0] pct_uv = 8'(PCT_UV_BASE + PCT_UV_STEP * int'(fwd[PCT_UV_LO +: 3]));
	// Orderings are checked here because the device accepts any threshold pattern
	wire pct_wrong = new_cmd == CMD_PCT_THRESH && (pct_warn >= pct_fault || pct_uv >= pct_warn);
	wire limit_zero = new_cmd == CMD_OC_LIMIT && fwd[10:0] == 11'h0;
	wire launch_req = do_write && wa == HOST_CMD_OFS && ws[0];
	wire refuse = launch_req && (busy || (new_write && (pct_wrong || limit_zero)));
	wire launch = launch_req && !refuse;
	wire [15:0] merged = {ws[1] ? wd[15:8] : wdata_reg[15:8], ws[0] ? wd[7:0] : wdata_reg[7:0]};
	logic rd_block;
	// Block replies must carry a count of one, otherwise the answer is flagged as a nack
	wire bad_count = rd_block && link.rsp_data[7:0] != BLOCK_COUNT;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= AXI_OKAY;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			aw_got <= aw_now && !do_write;
			w_got <= w_now && !do_write;
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wa_ok ? AXI_OKAY : AXI_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= AXI_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= ar_ok ? AXI_OKAY : AXI_SLVERR;
				case (s_axi_araddr)
					HOST_CMD_OFS: s_axi_rdata <= {15'h0, link.req_write, 6'h0, link.req_len, link.req_cmd};
					HOST_WDATA_OFS: s_axi_rdata <= {16'h0, wdata_reg};
					HOST_STATUS_OFS: s_axi_rdata <= {29'h0, refused, nack, busy};
					HOST_RDATA_OFS: s_axi_rdata <= {16'h0, rdata_reg};
					default: s_axi_rdata <= 32'h0;
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wdata_reg <= 16'h0;
			rdata_reg <= 16'h0;
			busy <= 1'b0;
			nack <= 1'b0;
			refused <= 1'b0;
			rd_block <= 1'b0;
			link.req_valid <= 1'b0;
			link.req_write <= 1'b0;
			link.req_cmd <= 8'h0;
			link.req_len <= LEN_NONE;
			link.req_data <= 16'h0;
		end else if (clk_en) begin
			if (do_write && wa == HOST_WDATA_OFS) begin
				wdata_reg <= merged;
			end
			refused <= refuse || (refused && !(do_write && wa == HOST_STATUS_OFS && ws[0] && wd[2]));
			if (launch) begin
				busy <= 1'b1;
				link.req_valid <= 1'b1;
				link.req_write <= new_write;
				link.req_cmd <= new_cmd;
				rd_block <= !new_write && is_rd_block;
				link.req_len <= new_write && is_block ? LEN_WORD : wd[HOST_LEN_LO +: 2];
				link.req_data <= new_write && is_block ? {fwd[15:8], BLOCK_COUNT} : fwd;
			end else if (link.req_valid && link.req_ready) begin
				link.req_valid <= 1'b0;
			end
			if (busy && !link.req_valid && link.rsp_valid) begin
				busy <= 1'b0;
				nack <= link.rsp_nack || bad_count;
				rdata_reg <= link.rsp_data;
			end
		end
	end
endmodule : pmc_host
`default_nettype wire
